// ---- include/wdg_pkg.sv ----
// Shared constants for the watchdog device end and its host-side controller.
// Assumes both ends run on the same system clock (sys_clk, 25 MHz).
package wdg_pkg;

   // Counter width and device register addresses (control shares its address with reset status)
   localparam int WDG_CNT_W = 24;
   localparam logic [11:0] WDG_ADDR_CTL = 12'h0FF0;
   localparam logic [11:0] WDG_ADDR_UPPER = 12'h0FF1;
   localparam logic [11:0] WDG_ADDR_MID = 12'h0FF2;
   localparam logic [11:0] WDG_ADDR_LOW = 12'h0FF3;

   // Unlock pair written to the control address
   localparam logic [7:0] WDG_UNLOCK_1 = 8'h55;
   localparam logic [7:0] WDG_UNLOCK_2 = 8'hAA;

   // Reload byte positions inside the 24-bit value
   localparam int WDG_UPPER_LSB = 16;
   localparam int WDG_MID_LSB = 8;
   localparam int WDG_LOW_LSB = 0;

   // Reload reset value (upper, middle, low bytes concatenated)
   localparam logic [23:0] WDG_RELOAD_RST = 24'h00_0400;

   // Counter landmarks
   localparam logic [23:0] WDG_CNT_MAX = 24'h0F_FFFF;
   localparam logic [23:0] WDG_NO_REFRESH = 24'h00_0002;
   localparam logic [23:0] WDG_MIN_RELOAD = 24'h00_0004;
   localparam logic [23:0] WDG_CNT_ONE = 24'h00_0001;

   // Reset status byte: bit positions of the watchdog and stop flags
   localparam int WDG_STAT_WDG_BIT = 5;
   localparam int WDG_STAT_STOP_BIT = 4;

   // Host controller word offsets on AHB-Lite
   localparam logic [7:0] HOST_OFS_CMD = 8'h00;
   localparam logic [7:0] HOST_OFS_ADDR = 8'h04;
   localparam logic [7:0] HOST_OFS_WDATA = 8'h08;
   localparam logic [7:0] HOST_OFS_RDATA = 8'h0C;
   localparam logic [7:0] HOST_OFS_EVENT = 8'h10;

   // Host field positions
   localparam int HOST_CMD_REFRESH_BIT = 0;
   localparam int HOST_CMD_STOP_BIT = 1;
   localparam int HOST_RDATA_VALID_BIT = 8;
   localparam int HOST_EV_IRQ_BIT = 0;
   localparam int HOST_EV_RESET_BIT = 1;
   localparam int HOST_EV_SMR_BIT = 2;

   // Reload lock sequencer
   typedef enum logic [2:0] {
      LK_LOCKED,
      LK_GOT55,
      LK_OPEN,
      LK_GOT_UP,
      LK_GOT_MID
   } wdg_lock_t;

endpackage

// ---- include/wdg_if.sv ----
// Link between the watchdog device end and the CPU-side controller.
// Assumes a single clock shared by both ends; all signals change after sys_clk rising edges.
`timescale 1ns/1ps
interface wdg_if;
   // Register access, one-cycle strobes from the controller
   logic reg_wr;
   logic reg_rd;
   logic [11:0] reg_addr;
   logic [7:0] reg_wdata;
   // Read data, valid the cycle after a read strobe
   logic [7:0] reg_rdata;
   // Refresh instruction pulse and stop mode level
   logic refresh;
   logic stop_mode;
   // Timeout responses, one-cycle pulses
   logic irq_req;
   logic reset_req;
   logic stop_recovery;

   modport dev (
      input reg_wr, reg_rd, reg_addr, reg_wdata, refresh, stop_mode,
      output reg_rdata, irq_req, reset_req, stop_recovery
   );

   modport host (
      output reg_wr, reg_rd, reg_addr, reg_wdata, refresh, stop_mode,
      input reg_rdata, irq_req, reset_req, stop_recovery
   );
endinterface

// ---- rtl/wdg_dev.sv ----
// Watchdog device end: 24-bit reloadable down-counter clocked by ticks of an RC oscillator pin.
// Assumes the controller on wdg_if shares sys_clk; rc_osc and the option pins are asynchronous.
// Option pins should stay static; reloads below four are not blocked.
// Timeout responses are one-cycle pulses; the controller keeps them.
// Operation
// R01 - 24-bit reloadable retriggerable down-counting watchdog
// R02 - Only on/off; once enabled never disabled
// R03 - Always-on option starts counting after reset
// R04 - Counter decrements on RC oscillator ticks
// R05 - Reload is upper, middle, low bytes
// R06 - Refresh ignored at count two or below
// R07 - Software never programs reload below four
// R08 - First enable loads counter from reload
// R09 - Refresh reloads counter, counting then continues
// R10 - Timeout when counter reaches zero
// R11 - Option selects interrupt or reset response
// R12 - Interrupt mode: request interrupt, set flag
// R13 - Interrupt timeout sets counter to FFFFFh
// R14 - Status read clears timeout flag
// R15 - Interrupt in stop: recovery, interrupt, flags
// R16 - Reset mode: force system reset, flag
// R17 - Reset in stop: recovery, both flags
// R18 - Unlock pair 55h, AAh on control
// R19 - Software writes upper, middle, low uninterrupted
// R20 - Stray write relocks, refusing reload writes
// R21 - Debugger keeps refreshing to avoid timeout
// R22 - Reload byte reads return live count
// R23 - Oscillator ticks synchronised, none lost or doubled
`timescale 1ns/1ps
module wdg_dev
   import wdg_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Oscillator and option pins, asynchronous
   input wire logic rc_osc,
   input wire logic always_on_option,
   input wire logic timeout_response_select,
   // CPU side
   wdg_if.dev bus
);

   // Whole state of the device end
   typedef struct packed {
      logic [1:0] osc_sync;       // Oscillator synchroniser
      logic osc_prev;             // Last synchronised oscillator level
      logic [1:0] ao_sync;        // Always-on option synchroniser
      logic [1:0] res_sync;       // Response select synchroniser
      logic enabled;              // Watchdog running
      logic [23:0] cnt;           // Live down-counter
      logic [23:0] reload;        // Stored reload value
      wdg_lock_t lock;            // Reload unlock sequencer
      logic wdg_flag;             // Timeout status flag
      logic stop_flag;            // Timeout happened in stop mode
      logic [7:0] rdata;          // Read data register
      logic irq;                  // Interrupt request pulse
      logic rst;                  // System reset request pulse
      logic smr;                  // Stop mode recovery pulse
   } wdg_dev_st_t;

   // Current state and its next value
   wdg_dev_st_t st_r;
   wdg_dev_st_t st_nxt;

   // Derived conditions
   logic tick;        // One sys_clk cycle per oscillator rising edge
   logic ao_on;       // Synchronised always-on option
   logic irq_mode;    // Synchronised response select, high selects interrupt
   logic timeout;     // Counter steps from one to zero this cycle
   logic refresh_ok;  // Refresh the counter accepts this cycle

   // Edge detect sees only the second synchroniser flop, so each oscillator rising edge gives one tick
   assign tick = st_r.osc_sync[1] & ~st_r.osc_prev;  // [R04] [R23]
   // Option levels after synchronisation
   assign ao_on = st_r.ao_sync[1];
   assign irq_mode = st_r.res_sync[1];
   // Refresh counts while off or above two; refused, it keeps the tick
   assign refresh_ok = bus.refresh & (~st_r.enabled | (st_r.cnt > WDG_NO_REFRESH));  // [R06]
   // Timeout on the step into zero; a refresh at one is refused, so cannot mask it
   assign timeout = st_r.enabled & tick & (st_r.cnt == WDG_CNT_ONE);  // [R10]

   // Outputs straight from flops
   // Read data holds until the next read
   assign bus.reg_rdata = st_r.rdata;
   assign bus.irq_req = st_r.irq;
   assign bus.reset_req = st_r.rst;
   assign bus.stop_recovery = st_r.smr;

   // Next-state logic
   always_comb begin
      st_nxt = st_r;
      // Every field holds unless a branch below changes it

      // Synchronisers: first flop feeds only the second
      // A changed option level takes effect two cycles late
      st_nxt.osc_sync = {st_r.osc_sync[0], rc_osc};  // [R23]
      st_nxt.osc_prev = st_r.osc_sync[1];
      st_nxt.ao_sync = {st_r.ao_sync[0], always_on_option};
      st_nxt.res_sync = {st_r.res_sync[0], timeout_response_select};

      // Response pulses last one cycle
      // Timeouts are at least four ticks apart when the reload is four or more
      st_nxt.irq = 1'b0;
      st_nxt.rst = 1'b0;
      st_nxt.smr = 1'b0;

      // Register writes drive the unlock sequencer
      if (bus.reg_wr) begin
         // Any write that is not the expected next step relocks
         st_nxt.lock = LK_LOCKED;  // [R20]
         if (bus.reg_addr == WDG_ADDR_CTL) begin
            // Control writes only steer the sequencer, no control bit changes
            if (bus.reg_wdata == WDG_UNLOCK_1) begin
               // A repeated 55h restarts at the second step
               st_nxt.lock = LK_GOT55;  // [R18]
            end else if (bus.reg_wdata == WDG_UNLOCK_2 && st_r.lock == LK_GOT55) begin
               st_nxt.lock = LK_OPEN;  // [R18]
            end
         end else if (bus.reg_addr == WDG_ADDR_UPPER && st_r.lock == LK_OPEN) begin
            // Upper byte is the most significant part of the reload value
            st_nxt.reload[WDG_UPPER_LSB +: 8] = bus.reg_wdata;  // [R05] [R19]
            st_nxt.lock = LK_GOT_UP;
         end else if (bus.reg_addr == WDG_ADDR_MID && st_r.lock == LK_GOT_UP) begin
            // Middle byte
            st_nxt.reload[WDG_MID_LSB +: 8] = bus.reg_wdata;  // [R05] [R19]
            st_nxt.lock = LK_GOT_MID;
         end else if (bus.reg_addr == WDG_ADDR_LOW && st_r.lock == LK_GOT_MID) begin
            // Low byte ends the sequence; the next change needs a new unlock
            st_nxt.reload[WDG_LOW_LSB +: 8] = bus.reg_wdata;  // [R05] [R19]
            st_nxt.lock = LK_LOCKED;
         end
      end

      // Register reads
      if (bus.reg_rd) begin
         // Unmapped addresses read zero
         st_nxt.rdata = 8'h00;
         if (bus.reg_addr == WDG_ADDR_CTL) begin
            // Reset status: reading returns both flags and clears them
            st_nxt.rdata[WDG_STAT_WDG_BIT] = st_r.wdg_flag;
            st_nxt.rdata[WDG_STAT_STOP_BIT] = st_r.stop_flag;
            st_nxt.wdg_flag = 1'b0;  // [R14]
            st_nxt.stop_flag = 1'b0;  // [R14]
         end else if (bus.reg_addr == WDG_ADDR_UPPER) begin
            // Reload byte addresses read back the live count, not the reload
            st_nxt.rdata = st_r.cnt[WDG_UPPER_LSB +: 8];  // [R22]
         end else if (bus.reg_addr == WDG_ADDR_MID) begin
            // Middle byte of the live count
            st_nxt.rdata = st_r.cnt[WDG_MID_LSB +: 8];  // [R22]
         end else if (bus.reg_addr == WDG_ADDR_LOW) begin
            // Bytes are read singly, so a running count can tear
            st_nxt.rdata = st_r.cnt[WDG_LOW_LSB +: 8];  // [R22]
         end
      end

      // Counter control; one of refresh, start, timeout or tick acts per cycle
      if (refresh_ok) begin
         if (!st_r.enabled) begin
            // First enable by refresh loads the reload value
            st_nxt.enabled = 1'b1;  // [R02]
            st_nxt.cnt = st_r.reload;  // [R08]
         end else begin
            // Refresh restarts the count from the reload; a refused one falls through to the tick
            st_nxt.cnt = st_r.reload;  // [R06] [R09]
         end
      end else if (!st_r.enabled) begin
         // Always-on option starts the counter with no refresh needed
         if (ao_on) begin
            st_nxt.enabled = 1'b1;  // [R03]
            st_nxt.cnt = st_r.reload;  // [R08]
         end
      end else if (timeout) begin
         // Flags set after the read clear above, so a timeout in the read cycle is kept
         st_nxt.wdg_flag = 1'b1;  // [R12] [R16]
         if (bus.stop_mode) begin
            // Wake the core from stop in either response mode
            st_nxt.smr = 1'b1;  // [R15] [R17]
            st_nxt.stop_flag = 1'b1;  // [R15] [R17]
         end
         if (irq_mode) begin
            // Interrupt response keeps counting from the maximum, not the reload
            st_nxt.irq = 1'b1;  // [R11] [R12] [R15]
            // 20-bit maximum; the top four bits clear
            st_nxt.cnt = WDG_CNT_MAX;  // [R13]
         end else begin
            // Reset response; a stop-mode timeout only recovers, no reset
            st_nxt.rst = ~bus.stop_mode;  // [R11] [R16]
            // Reload and run on; system reset comes from outside
            st_nxt.cnt = st_r.reload;
         end
      end else if (tick) begin
         // Plain down-count; once enabled there is no way back to off
         // Zero here only follows a reload below four
         st_nxt.cnt = st_r.cnt - WDG_CNT_ONE;  // [R01] [R04]
      end
   end

   // State register; enable is only ever set, never cleared except by reset
   // Synchronous reset brings back the default reload value
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r <= '0;
         st_r.reload <= WDG_RELOAD_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule

// ---- rtl/wdg_host.sv ----
// Host-side controller: an AHB-Lite slave that turns software word accesses into watchdog link traffic.
// Assumes one AHB-Lite master on sys_clk; hready is driven from this slave's hreadyout.
`timescale 1ns/1ps
module wdg_host
   import wdg_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Watchdog link
   wdg_if.host link
);

   // Whole state of the controller
   typedef struct packed {
      logic ap_valid;          // Write data phase pending
      logic [7:0] ap_addr;     // Latched write offset
      logic [31:0] hrdata;     // Read data for the data phase
      logic ready;             // Always ready, zero wait states
      logic [11:0] tgt_addr;   // Device register address
      logic [7:0] wdata;       // Byte for the device
      logic reg_wr;            // Write strobe
      logic reg_rd;            // Read strobe
      logic rd_wait;           // Device read data lands next cycle
      logic [7:0] rd_byte;     // Captured device read data
      logic rd_valid;          // Captured byte is fresh
      logic refresh;           // Refresh pulse
      logic stop_mode;         // Stop mode level
      logic [2:0] events;      // Sticky response events
   } wdg_host_st_t;

   wdg_host_st_t st_r;
   wdg_host_st_t st_nxt;
   logic ap_take;   // Address phase accepted this cycle

   // Size is ignored: only whole-word single transfers are supported
   assign ap_take = hsel & htrans[1] & hready;

   // Outputs straight from flops; hresp is tied to OKAY
   assign hrdata = st_r.hrdata;
   assign hreadyout = st_r.ready;
   assign hresp = 1'b0;
   assign link.reg_addr = st_r.tgt_addr;
   assign link.reg_wdata = st_r.wdata;
   assign link.reg_wr = st_r.reg_wr;
   assign link.reg_rd = st_r.reg_rd;
   assign link.refresh = st_r.refresh;
   assign link.stop_mode = st_r.stop_mode;

   // Next-state logic
   always_comb begin
      st_nxt = st_r;
      st_nxt.ready = 1'b1;
      st_nxt.reg_wr = 1'b0;
      st_nxt.reg_rd = 1'b0;
      st_nxt.refresh = 1'b0;
      st_nxt.ap_valid = 1'b0;

      // Device read data: strobe, then one cycle later the byte is valid
      st_nxt.rd_wait = st_r.reg_rd;
      if (st_r.rd_wait) begin
         st_nxt.rd_byte = link.reg_rdata;
         st_nxt.rd_valid = 1'b1;
      end

      // Address phase: reads are answered from current state, writes wait for data
      if (ap_take) begin
         st_nxt.hrdata = 32'h0000_0000;
         if (hwrite) begin
            st_nxt.ap_valid = 1'b1;
            st_nxt.ap_addr = haddr[7:0];
         end else if (haddr[7:0] == HOST_OFS_CMD) begin
            st_nxt.hrdata[HOST_CMD_STOP_BIT] = st_r.stop_mode;
         end else if (haddr[7:0] == HOST_OFS_ADDR) begin
            st_nxt.hrdata[11:0] = st_r.tgt_addr;
         end else if (haddr[7:0] == HOST_OFS_RDATA) begin
            st_nxt.hrdata[7:0] = st_r.rd_byte;
            st_nxt.hrdata[HOST_RDATA_VALID_BIT] = st_r.rd_valid;
         end else if (haddr[7:0] == HOST_OFS_EVENT) begin
            st_nxt.hrdata[2:0] = st_r.events;
         end
      end

      // Write data phase; unmapped offsets are ignored
      if (st_r.ap_valid) begin
         if (st_r.ap_addr == HOST_OFS_CMD) begin
            st_nxt.refresh = hwdata[HOST_CMD_REFRESH_BIT];
            st_nxt.stop_mode = hwdata[HOST_CMD_STOP_BIT];
         end else if (st_r.ap_addr == HOST_OFS_ADDR) begin
            st_nxt.tgt_addr = hwdata[11:0];
         end else if (st_r.ap_addr == HOST_OFS_WDATA) begin
            st_nxt.wdata = hwdata[7:0];
            st_nxt.reg_wr = 1'b1;
         end else if (st_r.ap_addr == HOST_OFS_RDATA) begin
            // Starting a read marks the old byte stale
            st_nxt.reg_rd = 1'b1;
            st_nxt.rd_valid = 1'b0;
         end else if (st_r.ap_addr == HOST_OFS_EVENT) begin
            // Write one to clear
            st_nxt.events = st_r.events & ~hwdata[2:0];
         end
      end

      // Device events set after the clear, so a set in the clear cycle wins
      if (link.irq_req) begin
         st_nxt.events[HOST_EV_IRQ_BIT] = 1'b1;
      end
      if (link.reset_req) begin
         st_nxt.events[HOST_EV_RESET_BIT] = 1'b1;
      end
      if (link.stop_recovery) begin
         st_nxt.events[HOST_EV_SMR_BIT] = 1'b1;
      end
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r <= '0;
         st_r.ready <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule

// ---- bench/wdg_asserts.sv ----
// Checker for the watchdog link: timeout pulses, stop responses and read data.
// Assumes it sits beside the wdg_if instance and shares sys_clk and sys_rst.
`timescale 1ns/1ps
module wdg_asserts
   import wdg_pkg::*;
(
   // Clock and reset
   input logic sys_clk,
   input logic sys_rst,
   // Register read path
   input logic reg_rd,
   input logic [11:0] reg_addr,
   input logic [7:0] reg_rdata,
   // Timeout responses and stop level
   input logic stop_mode,
   input logic irq_req,
   input logic reset_req,
   input logic stop_recovery
);
   // One clock domain, so clocking and disable are stated once
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   // Counter jumps high after an interrupt, so no second request can follow soon
   a_irq_pulse_gap: assert property (irq_req |=> !irq_req [*8]) // Quiet after interrupt
      else $error("interrupt request repeated too soon");
   // Reset mode reloads the stored reload value, so requests are spaced when it is four or more
   a_rst_pulse_gap: assert property (reset_req |=> !reset_req [*8]) // Quiet after reset request
      else $error("reset request repeated too soon");
   // Recovery start is a single pulse
   a_smr_one_cycle: assert property (stop_recovery |=> !stop_recovery) // Single recovery pulse
      else $error("stop recovery longer than one cycle");
   // Only one response kind per timeout
   a_resp_exclusive: assert property (!(irq_req && reset_req)) // One response kind
      else $error("interrupt and reset requested together");
   // Reset request only outside stop mode
   a_rst_not_stop: assert property (reset_req |-> !$past(stop_mode)) // Reset only when running
      else $error("reset request while in stop mode");
   // Recovery only from stop mode
   a_smr_in_stop: assert property (stop_recovery |-> $past(stop_mode)) // Recovery needs stop
      else $error("stop recovery outside stop mode");
   // Recovery in reset mode replaces the reset request
   a_smr_no_rst: assert property (stop_recovery |-> !reset_req) // Recovery without reset
      else $error("reset request beside stop recovery");
   // Read data moves only in answer to a read strobe
   a_rdata_on_read: assert property ($changed(reg_rdata) |-> $past(reg_rd)) // Data follows read
      else $error("read data changed without a read");

   // Main scenarios reached
   c_irq: cover property (irq_req);
   c_rst: cover property (reset_req);
   c_smr_irq: cover property (stop_recovery && irq_req);
   c_stat_rd: cover property (reg_rd && reg_addr == WDG_ADDR_CTL);
endmodule

// ---- bench/wdg_tb.sv ----
// Bench for the watchdog pair: AHB-Lite master on the controller, oscillator and option pins on the device.
// Assumes a zero-wait controller; the oscillator pin is driven only here, slowly against sys_clk.
`timescale 1ns/1ps
module wdg_tb
   import wdg_pkg::*;
();
   // Clock, reset and device pins
   logic sys_clk, sys_rst, rc_osc, always_on_option, timeout_response_select;
   // AHB-Lite master side
   logic hsel, hwrite, hreadyout, hresp;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd_w;
   // Stop level kept across refresh writes, and last device byte
   logic stop_v;
   logic [7:0] rd_b;
   int fail_count, n_tests;
   // One timeout case: options in, events, status and count out
   typedef struct {
      logic resp;
      logic stop;
      logic [31:0] ev;
      logic [7:0] stat;
      logic [23:0] cnt;
   } wdg_row_t;
   wdg_row_t rows [4] = '{
      '{1'b1, 1'b0, 32'h0000_0001, 8'h20, WDG_CNT_MAX},
      '{1'b1, 1'b1, 32'h0000_0005, 8'h30, WDG_CNT_MAX},
      '{1'b0, 1'b0, 32'h0000_0002, 8'h20, 24'h00_0004},
      '{1'b0, 1'b1, 32'h0000_0004, 8'h30, 24'h00_0004}};

   wdg_if wdg_if_inst ();
   wdg_dev wdg_dev_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .rc_osc(rc_osc), .always_on_option(always_on_option),
      .timeout_response_select(timeout_response_select), .bus(wdg_if_inst));
   // The single slave's hreadyout is the bus hready
   wdg_host wdg_host_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .link(wdg_if_inst));
   wdg_asserts wdg_asserts_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_rd(wdg_if_inst.reg_rd),
      .reg_addr(wdg_if_inst.reg_addr), .reg_rdata(wdg_if_inst.reg_rdata), .stop_mode(wdg_if_inst.stop_mode),
      .irq_req(wdg_if_inst.irq_req), .reset_req(wdg_if_inst.reset_req), .stop_recovery(wdg_if_inst.stop_recovery));

   // 25 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // Verdict and end of run
   task automatic end_of_test();
      if (fail_count == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Report one mismatch
   task automatic fail(input string m);
      fail_count++;
      $display("[FAIL] %0t: %s", $time, m);
   endtask

   // Compare a bus word
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         fail(m);
      end
   endtask

   // Compare a device byte
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         fail(m);
      end
   endtask

   // Bounded wait for hready at a rising edge
   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 64);
      if (hreadyout !== 1'b1) begin
         fail("bus hang");
         end_of_test();
      end
   endtask

   // One single word transfer: address phase, then data phase
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask

   // Device register write through the controller
   task automatic dev_wr(input logic [11:0] a, input logic [7:0] b);
      ahb(1'b1, HOST_OFS_ADDR, {20'h0_0000, a}, rd_w);
      ahb(1'b1, HOST_OFS_WDATA, {24'h00_0000, b}, rd_w);
   endtask

   // Device register read; polls the valid bit under a bound
   task automatic dev_rd(input logic [11:0] a, output logic [7:0] b);
      int k;
      ahb(1'b1, HOST_OFS_ADDR, {20'h0_0000, a}, rd_w);
      ahb(1'b1, HOST_OFS_RDATA, 32'h0000_0000, rd_w);
      k = 0;
      do begin
         ahb(1'b0, HOST_OFS_RDATA, 32'h0000_0000, rd_w);
         k++;
      end while (rd_w[HOST_RDATA_VALID_BIT] !== 1'b1 && k < 16);
      if (k >= 16) begin
         fail("read never valid");
         end_of_test();
      end
      b = rd_w[7:0];
   endtask

   // Live count through the three byte addresses
   task automatic cnt_chk(input logic [23:0] exp);
      dev_rd(WDG_ADDR_UPPER, rd_b);
      chk_byte(rd_b, exp[23:16], "count upper");
      dev_rd(WDG_ADDR_MID, rd_b);
      chk_byte(rd_b, exp[15:8], "count middle");
      dev_rd(WDG_ADDR_LOW, rd_b);
      chk_byte(rd_b, exp[7:0], "count low");
   endtask

   // Full unlock pair followed by the three reload bytes
   task automatic load(input logic [7:0] u, input logic [7:0] m, input logic [7:0] l);
      dev_wr(WDG_ADDR_CTL, WDG_UNLOCK_1);
      dev_wr(WDG_ADDR_CTL, WDG_UNLOCK_2);
      dev_wr(WDG_ADDR_UPPER, u);
      dev_wr(WDG_ADDR_MID, m);
      dev_wr(WDG_ADDR_LOW, l);
   endtask

   // Refresh instruction; keeps the stop level as set
   task automatic refresh();
      ahb(1'b1, HOST_OFS_CMD, {30'h0000_0000, stop_v, 1'b1}, rd_w);
   endtask

   // Oscillator rising edges, each level well over two cycles
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         rc_osc <= 1'b1;
         repeat (3) @(posedge sys_clk);
         rc_osc <= 1'b0;
         repeat (3) @(posedge sys_clk);
      end
   endtask

   // Reset held for two cycles
   task automatic do_reset();
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
   endtask

   // Main sequence: table of timeout cases, then hand-written cases
   initial begin
      sys_rst = 1'b1;
      rc_osc = 1'b0;
      always_on_option = 1'b0;
      timeout_response_select = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'b010;
      stop_v = 1'b0;
      fail_count = 0;
      n_tests = 0;
      foreach (rows[i]) begin
         timeout_response_select <= rows[i].resp;
         stop_v = rows[i].stop;
         do_reset();
         load(8'h00, 8'h00, 8'h04); // Smallest legal reload
         refresh(); // First enable loads the reload
         ticks(3);
         ahb(1'b0, HOST_OFS_EVENT, 32'h0000_0000, rd_w);
         chk_word(rd_w, 32'h0000_0000, "early timeout");
         ticks(1);
         ahb(1'b0, HOST_OFS_EVENT, 32'h0000_0000, rd_w);
         chk_word(rd_w, rows[i].ev, "timeout response");
         cnt_chk(rows[i].cnt);
         dev_rd(WDG_ADDR_CTL, rd_b);
         chk_byte(rd_b, rows[i].stat, "status flags");
         dev_rd(WDG_ADDR_CTL, rd_b);
         chk_byte(rd_b, 8'h00, "status after read");
         ahb(1'b1, HOST_OFS_EVENT, 32'h0000_0007, rd_w);
         ahb(1'b0, HOST_OFS_EVENT, 32'h0000_0000, rd_w);
         chk_word(rd_w, 32'h0000_0000, "events after clear");
      end
      // Disabled counter ignores ticks; refresh limits
      timeout_response_select <= 1'b1;
      stop_v = 1'b0;
      do_reset();
      ticks(1);
      cnt_chk(24'h00_0000);
      load(8'h00, 8'h00, 8'h05);
      refresh();
      ticks(2);
      refresh();
      cnt_chk(24'h00_0005);
      ticks(3);
      refresh();
      cnt_chk(24'h00_0002);
      ticks(2);
      ahb(1'b0, HOST_OFS_EVENT, 32'h0000_0000, rd_w);
      chk_word(rd_w, 32'h0000_0001, "timeout after refused refresh");
      dev_rd(WDG_ADDR_CTL, rd_b);
      chk_byte(rd_b, 8'h20, "status flags");
      // Stray write in mid sequence relocks the middle and low bytes
      dev_wr(WDG_ADDR_CTL, WDG_UNLOCK_1);
      dev_wr(WDG_ADDR_CTL, WDG_UNLOCK_2);
      dev_wr(WDG_ADDR_UPPER, 8'h12);
      dev_wr(WDG_ADDR_CTL, 8'h00);
      dev_wr(WDG_ADDR_MID, 8'h34);
      dev_wr(WDG_ADDR_LOW, 8'h77);
      refresh();
      cnt_chk(24'h12_0005);
      dev_rd(WDG_ADDR_CTL, rd_b);
      chk_byte(rd_b, 8'h00, "control writes set bits");
      load(8'h01, 8'h23, 8'h45);
      refresh();
      cnt_chk(24'h01_2345);
      // Always-on start from the reset reload value
      always_on_option <= 1'b1;
      do_reset();
      cnt_chk(WDG_RELOAD_RST);
      ticks(1);
      cnt_chk(WDG_RELOAD_RST - WDG_CNT_ONE);
      // Unmapped controller offset reads zero, response OKAY
      ahb(1'b0, 8'h20, 32'h0000_0000, rd_w);
      chk_word(rd_w, 32'h0000_0000, "unmapped read");
      chk_word({31'h0000_0000, hresp}, 32'h0000_0000, "bus response");
      end_of_test();
   end
endmodule
